// ### logic/icc_chain.sv
// Purpose: Input conditioning chain of a panel indicator, one pass per sample.
// Assumes: One sample per sampling period, from logic on ref_clk.
// Notes: Results queue in a FIFO that software drains over Avalon-MM.
`timescale 1ns/1ps
`include "icc_params.svh"

// Summary of operation
// - Internal junction compensation only when enabled
// - External junction value only when internal off
// - Add pv_bias to form measured value
// - Lag filter on process value, off bypasses
// - Add analog_bias on analog input path
// - Lag filter on analog path, off bypasses
// - Square root modes off, unity, zero below
// - Low cutoff compare without any hysteresis
// - Square root only for voltage or current
// - Linearizer mode bias or approximation, eleven points
// - Bias mode clamps to end bias points
// - Approximation extends end segments outside breakpoints
// - Breakpoint inputs limited to -66.7 to 105.0
module icc_chain (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Sample stream
   input wire logic sample_valid,
   output logic sample_ready,
   input wire icc_pkg::icc_sample_type sample_data
);

   icc_pkg::icc_state_type s_r;
   icc_pkg::icc_state_type s_nxt;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [15:0] fifo_out_data;
   logic [4:0] fifo_count;

   // Saturate a wide result to the 16-bit signal range
   function automatic logic [15:0] sat16(input logic signed [47:0] v);
      if (v > 48'sh0000_0000_7FFF) begin
         return 16'h7FFF;
      end else if (v < -48'sh0000_0000_8000) begin
         return 16'h8000;
      end
      return v[15:0];
   endfunction

   // Clamp a setting into its allowed range
   function automatic logic [15:0] clampv(input logic [15:0] v, input logic signed [15:0] lo,
                                          input logic signed [15:0] hi);
      if ($signed(v) < lo) begin
         return lo;
      end else if ($signed(v) > hi) begin
         return hi;
      end
      return v;
   endfunction

   // Merge the low two byte lanes of a write
   function automatic logic [15:0] be16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
      return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // Sign-extend to the common arithmetic width
   function automatic logic signed [47:0] sx(input logic [15:0] v);
      return 48'($signed(v));
   endfunction

   // Filter gain Ts / (tc + Ts) in 1/65536; zero means bypass
   function automatic logic [16:0] coef_of(input logic [15:0] tc);
      logic [31:0] den;
      den = 32'(tc) * `ICC_MS_PER_S + `ICC_TS_MS;
      if (tc == 16'h0000) begin
         return 17'h00000;
      end
      return 17'((`ICC_TS_MS << `ICC_COEF_SHIFT) / den);
   endfunction

   // First-order lag step; truncation leaves a small offset at long time constants
   function automatic logic [15:0] lag(input logic [15:0] y, input logic [15:0] x, input logic [16:0] c);
      logic signed [47:0] d;
      d = (sx(x) - sx(y)) * $signed({31'h0000_0000, c});
      return sat16(sx(y) + (d >>> `ICC_COEF_SHIFT));
   endfunction

   // Integer square root by bit trial
   function automatic logic [15:0] isqrt(input logic [31:0] v);
      logic [31:0] r;
      logic [31:0] t;
      r = 32'h0000_0000;
      for (int i = 15; i >= 0; i--) begin
         t = r | (32'h0000_0001 << i);
         if (t * t <= v) begin
            r = t;
         end
      end
      return r[15:0];
   endfunction

   // Straight line through two points, evaluated at x
   function automatic logic signed [47:0] interp(input logic [15:0] x, input logic [15:0] x0,
                                                 input logic [15:0] x1, input logic [15:0] y0,
                                                 input logic [15:0] y1);
      logic signed [47:0] dx;
      dx = sx(x1) - sx(x0);
      if (dx == 48'sh0) begin
         return sx(y0);
      end
      return sx(y0) + ((sx(x) - sx(x0)) * (sx(y1) - sx(y0))) / dx;
   endfunction

   // Eleven-point linearizer; a falling curve gives unspecified segments
   function automatic logic [15:0] lin_eval(input icc_pkg::icc_cfg_type c, input logic [15:0] x);
      logic [3:0] seg;
      logic signed [47:0] line;
      seg = 4'h0;
      for (int i = 1; i <= `ICC_SEG_LAST; i++) begin
         if ($signed(x) >= $signed(c.bp_in[i])) begin
            seg = 4'(i);
         end
      end
      line = interp(x, c.bp_in[seg], c.bp_in[seg + 4'h1], c.bp_out[seg], c.bp_out[seg + 4'h1]);
      if (c.lin_mode == `ICC_LIN_APPROX) begin
         return sat16(line);
      end
      if ($signed(x) <= $signed(c.bp_in[0])) begin
         return sat16(sx(x) + sx(c.bp_out[0]));
      end else if ($signed(x) >= $signed(c.bp_in[`ICC_BP_LAST])) begin
         return sat16(sx(x) + sx(c.bp_out[`ICC_BP_LAST]));
      end
      return sat16(sx(x) + line);
   endfunction

   // Handshakes; a pop follows the valid bit already captured, so a late push is never lost
   assign sample_ready = (s_r.st == icc_pkg::ST_IDLE);
   assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
   assign avs_readdata = s_r.rdata;
   assign fifo_out_ready = s_r.ack && avs_read && (avs_address == `ICC_ADDR_DATA) && s_r.rdata[`ICC_DATA_VALID];

   // Next state: sample sequence and register bus
   always_comb begin
      logic [31:0] rd;
      logic is_tc;
      logic is_vi;
      logic [3:0] idx;
      rd = 32'h0000_0000;
      s_nxt = s_r;
      is_tc = (s_r.cfg.in_type == `ICC_TYPE_TC);
      is_vi = (s_r.cfg.in_type == `ICC_TYPE_VOLT) || (s_r.cfg.in_type == `ICC_TYPE_CURR);
      idx = avs_address[3:0];
      unique case (s_r.st)
         icc_pkg::ST_IDLE: begin
            if (sample_valid) begin
               s_nxt.work = sample_data.value;
               s_nxt.cj = sample_data.cj;
               s_nxt.st = icc_pkg::ST_COMP;
            end
         end
         icc_pkg::ST_COMP: begin
            if (is_tc && s_r.cfg.comp_en) begin
               s_nxt.work = sat16(sx(s_r.work) + sx(s_r.cj));
            end else if (is_tc) begin
               s_nxt.work = sat16(sx(s_r.work) + sx(s_r.cfg.ext_jt));
            end
            s_nxt.st = icc_pkg::ST_SQRT;
         end
         icc_pkg::ST_SQRT: begin
            if (is_vi && s_r.cfg.sqrt_mode != `ICC_SQRT_OFF) begin
               if ($signed(s_r.work) < $signed(s_r.cfg.low_cut)) begin
                  s_nxt.work = (s_r.cfg.sqrt_mode == `ICC_SQRT_ZERO) ? 16'h0000 : s_r.work;
               end else begin
                  s_nxt.work = isqrt(32'(s_r.work) * `ICC_SQRT_SCALE);
               end
            end
            s_nxt.st = icc_pkg::ST_LIN;
         end
         icc_pkg::ST_LIN: begin
            if (s_r.cfg.lin_en) begin
               s_nxt.work = lin_eval(s_r.cfg, s_r.work);
            end
            s_nxt.st = icc_pkg::ST_ABIAS;
         end
         icc_pkg::ST_ABIAS: begin
            s_nxt.work = sat16(sx(s_r.work) + sx(s_r.cfg.a_bias));
            s_nxt.st = icc_pkg::ST_AFILT;
         end
         icc_pkg::ST_AFILT: begin
            // First sample or bypass loads the filter so it never starts from zero
            if (s_r.a_coef == 17'h00000 || !s_r.a_prim) begin
               s_nxt.a_y = s_r.work;
            end else begin
               s_nxt.a_y = lag(s_r.a_y, s_r.work, s_r.a_coef);
               s_nxt.work = s_nxt.a_y;
            end
            s_nxt.a_prim = 1'b1;
            s_nxt.st = icc_pkg::ST_PBIAS;
         end
         icc_pkg::ST_PBIAS: begin
            s_nxt.work = sat16(sx(s_r.work) + sx(s_r.cfg.pv_bias));
            s_nxt.st = icc_pkg::ST_PFILT;
         end
         icc_pkg::ST_PFILT: begin
            if (s_r.p_coef == 17'h00000 || !s_r.p_prim) begin
               s_nxt.p_y = s_r.work;
            end else begin
               s_nxt.p_y = lag(s_r.p_y, s_r.work, s_r.p_coef);
               s_nxt.work = s_nxt.p_y;
            end
            s_nxt.p_prim = 1'b1;
            s_nxt.st = icc_pkg::ST_PUSH;
         end
         icc_pkg::ST_PUSH: begin
            // A full queue holds the chain, which holds off the next sample
            if (fifo_in_ready) begin
               s_nxt.st = icc_pkg::ST_IDLE;
            end
         end
      endcase

      // Read mux; unmapped words read zero
      unique case (avs_address)
         `ICC_ADDR_CTRL: rd[6:0] = {s_r.cfg.lin_en, s_r.cfg.lin_mode, s_r.cfg.sqrt_mode,
                                    s_r.cfg.comp_en, s_r.cfg.in_type};
         `ICC_ADDR_EXT: rd = 32'($signed(s_r.cfg.ext_jt));
         `ICC_ADDR_PVB: rd = 32'($signed(s_r.cfg.pv_bias));
         `ICC_ADDR_PVTC: rd[15:0] = s_r.cfg.pv_tc;
         `ICC_ADDR_AB: rd = 32'($signed(s_r.cfg.a_bias));
         `ICC_ADDR_ATC: rd[15:0] = s_r.cfg.a_tc;
         `ICC_ADDR_LC: rd[15:0] = s_r.cfg.low_cut;
         `ICC_ADDR_STAT: begin
            rd[`ICC_STAT_CNT] = fifo_count;
            rd[`ICC_STAT_EMPTY] = !fifo_out_valid;
            rd[`ICC_STAT_FULL] = !fifo_in_ready;
            rd[`ICC_STAT_BUSY] = (s_r.st != icc_pkg::ST_IDLE);
         end
         `ICC_ADDR_DATA: rd[16:0] = {fifo_out_valid, fifo_out_data};
         default: begin
            if (avs_address[5:4] == `ICC_ADDR_BPI && idx < `ICC_BP_N) begin
               rd = 32'($signed(s_r.cfg.bp_in[idx]));
            end else if (avs_address[5:4] == `ICC_ADDR_BPO && idx < `ICC_BP_N) begin
               rd = 32'($signed(s_r.cfg.bp_out[idx]));
            end
         end
      endcase

      // Two-cycle transfer: data taken in cycle 0, write committed at the release edge
      s_nxt.ack = (avs_read || avs_write) && !s_r.ack;
      if (avs_read && !s_r.ack) begin
         s_nxt.rdata = rd;
      end
      if (avs_write && s_r.ack) begin
         unique case (avs_address)
            `ICC_ADDR_CTRL: begin
               if (avs_byteenable[0]) begin
                  s_nxt.cfg.in_type = avs_writedata[`ICC_CTRL_TYPE];
                  s_nxt.cfg.comp_en = avs_writedata[`ICC_CTRL_COMP];
                  s_nxt.cfg.sqrt_mode = avs_writedata[`ICC_CTRL_SQRT];
                  s_nxt.cfg.lin_mode = avs_writedata[`ICC_CTRL_LMODE];
                  s_nxt.cfg.lin_en = avs_writedata[`ICC_CTRL_LEN];
               end
            end
            `ICC_ADDR_EXT: s_nxt.cfg.ext_jt = clampv(be16(s_r.cfg.ext_jt, avs_writedata, avs_byteenable),
                                                     `ICC_EXT_MIN, `ICC_EXT_MAX);
            `ICC_ADDR_PVB: s_nxt.cfg.pv_bias = clampv(be16(s_r.cfg.pv_bias, avs_writedata, avs_byteenable),
                                                      `ICC_BIAS_MIN, `ICC_BIAS_MAX);
            `ICC_ADDR_PVTC: begin
               s_nxt.cfg.pv_tc = clampv(be16(s_r.cfg.pv_tc, avs_writedata, avs_byteenable), 16'sh0000,
                                        `ICC_TC_MAX);
               s_nxt.p_coef = coef_of(s_nxt.cfg.pv_tc);
            end
            `ICC_ADDR_AB: s_nxt.cfg.a_bias = clampv(be16(s_r.cfg.a_bias, avs_writedata, avs_byteenable),
                                                    `ICC_BIAS_MIN, `ICC_BIAS_MAX);
            `ICC_ADDR_ATC: begin
               s_nxt.cfg.a_tc = clampv(be16(s_r.cfg.a_tc, avs_writedata, avs_byteenable), 16'sh0000,
                                       `ICC_TC_MAX);
               s_nxt.a_coef = coef_of(s_nxt.cfg.a_tc);
            end
            `ICC_ADDR_LC: s_nxt.cfg.low_cut = clampv(be16(s_r.cfg.low_cut, avs_writedata, avs_byteenable),
                                                     16'sh0000, `ICC_LC_MAX);
            default: begin
               if (avs_address[5:4] == `ICC_ADDR_BPI && idx < `ICC_BP_N) begin
                  s_nxt.cfg.bp_in[idx] = clampv(be16(s_r.cfg.bp_in[idx], avs_writedata, avs_byteenable),
                                                `ICC_BP_MIN, `ICC_BP_MAX);
               end else if (avs_address[5:4] == `ICC_ADDR_BPO && idx < `ICC_BP_N) begin
                  s_nxt.cfg.bp_out[idx] = clampv(be16(s_r.cfg.bp_out[idx], avs_writedata, avs_byteenable),
                                                 `ICC_BP_MIN, `ICC_BP_MAX);
               end
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
         s_r.st <= icc_pkg::ST_IDLE;
         s_r.cfg.comp_en <= 1'(`ICC_CTRL_RST >> `ICC_CTRL_COMP);
      end else begin
         s_r <= s_nxt;
      end
   end

   // Output queue, drained by reads of the data word
   icc_fifo #(.W(16), .D(16)) u_fifo (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .in_valid(s_r.st == icc_pkg::ST_PUSH),
      .in_ready(fifo_in_ready),
      .in_data(s_r.work),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data),
      .count(fifo_count)
   );

   // Checks on the chain
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_bus_one_wait: assert property ((avs_read || avs_write) && !s_r.ack |=> !avs_waitrequest)
      else $error("bus answer late");
   a_comp_internal: assert property (s_r.st == icc_pkg::ST_COMP && s_r.cfg.in_type == `ICC_TYPE_TC
      && s_r.cfg.comp_en |=> s_r.work == sat16(sx($past(s_r.work)) + sx($past(s_r.cj))))
      else $error("internal compensation wrong");
   a_comp_external: assert property (s_r.st == icc_pkg::ST_COMP && s_r.cfg.in_type == `ICC_TYPE_TC
      && !s_r.cfg.comp_en |=> s_r.work == sat16(sx($past(s_r.work)) + sx($past(s_r.cfg.ext_jt))))
      else $error("external compensation wrong");
   a_sqrt_gated: assert property (s_r.st == icc_pkg::ST_SQRT && (s_r.cfg.sqrt_mode == `ICC_SQRT_OFF
      || !s_r.cfg.in_type[1]) |=> $stable(s_r.work))
      else $error("square root applied when off");
   a_cut_zero: assert property (s_r.st == icc_pkg::ST_SQRT && s_r.cfg.in_type[1]
      && s_r.cfg.sqrt_mode == `ICC_SQRT_ZERO && $signed(s_r.work) < $signed(s_r.cfg.low_cut)
      |=> s_r.work == 16'h0000)
      else $error("cutoff not zeroed");
   a_lin_low_bias: assert property (s_r.st == icc_pkg::ST_LIN && s_r.cfg.lin_en
      && s_r.cfg.lin_mode == `ICC_LIN_BIAS && $signed(s_r.work) <= $signed(s_r.cfg.bp_in[0])
      |=> s_r.work == sat16(sx($past(s_r.work)) + sx($past(s_r.cfg.bp_out[0]))))
      else $error("low end bias wrong");
   a_pv_bias: assert property (s_r.st == icc_pkg::ST_PBIAS
      |=> s_r.work == sat16(sx($past(s_r.work)) + sx($past(s_r.cfg.pv_bias))))
      else $error("pv bias wrong");
   a_analog_bias: assert property (s_r.st == icc_pkg::ST_ABIAS
      |=> s_r.work == sat16(sx($past(s_r.work)) + sx($past(s_r.cfg.a_bias))))
      else $error("analog bias wrong");
   a_filt_bypass: assert property (s_r.st == icc_pkg::ST_PFILT && s_r.cfg.pv_tc == 16'h0000
      |=> $stable(s_r.work))
      else $error("pv filter not bypassed");
   a_afilt_bypass: assert property (s_r.st == icc_pkg::ST_AFILT && s_r.cfg.a_tc == 16'h0000
      |=> $stable(s_r.work))
      else $error("analog filter not bypassed");
   a_filt_once: assert property (s_r.st != icc_pkg::ST_PFILT |=> $stable(s_r.p_y))
      else $error("pv filter moved outside its step");
   a_stage_order: assert property (s_r.st == icc_pkg::ST_COMP |=> s_r.st == icc_pkg::ST_SQRT
      ##1 s_r.st == icc_pkg::ST_LIN ##1 s_r.st == icc_pkg::ST_ABIAS ##1 s_r.st == icc_pkg::ST_AFILT
      ##1 s_r.st == icc_pkg::ST_PBIAS ##1 s_r.st == icc_pkg::ST_PFILT ##1 s_r.st == icc_pkg::ST_PUSH)
      else $error("stage order broken");
   a_bp_range: assert property ($signed(s_r.cfg.bp_in[0]) >= `ICC_BP_MIN
      && $signed(s_r.cfg.bp_in[`ICC_BP_LAST]) <= `ICC_BP_MAX)
      else $error("breakpoint out of range");

   c_sample_done: cover property (s_r.st == icc_pkg::ST_PUSH && fifo_in_ready);
   c_fifo_full: cover property (s_r.st == icc_pkg::ST_PUSH && !fifo_in_ready);
   c_approx_mode: cover property (s_r.st == icc_pkg::ST_LIN && s_r.cfg.lin_en && s_r.cfg.lin_mode);
   c_sqrt_run: cover property (s_r.st == icc_pkg::ST_SQRT && s_r.cfg.in_type[1]
      && s_r.cfg.sqrt_mode == `ICC_SQRT_UNITY);
endmodule

// ### logic/icc_params.svh
// Purpose: Named constants of the input conditioning chain.
// Assumes: Signal values are signed 16-bit counts of 0.1 % of the input range.
// Notes: Definitions only; included by the chain module, not by the package or the FIFO.
`ifndef ICC_PARAMS_SVH
`define ICC_PARAMS_SVH

// Timing
`define ICC_TS_MS 32'h0000_0064
`define ICC_MS_PER_S 32'h0000_03E8
`define ICC_COEF_SHIFT 16
`define ICC_SQRT_SCALE 32'h0000_03E8

// Word addresses on the register bus
`define ICC_ADDR_CTRL 6'h00
`define ICC_ADDR_EXT 6'h01
`define ICC_ADDR_PVB 6'h02
`define ICC_ADDR_PVTC 6'h03
`define ICC_ADDR_AB 6'h04
`define ICC_ADDR_ATC 6'h05
`define ICC_ADDR_LC 6'h06
`define ICC_ADDR_STAT 6'h07
`define ICC_ADDR_DATA 6'h08
`define ICC_ADDR_BPI 2'h1
`define ICC_ADDR_BPO 2'h2
`define ICC_BP_N 4'hB
`define ICC_BP_LAST 4'hA
`define ICC_SEG_LAST 4'h9

// Control field positions and reset value
`define ICC_CTRL_TYPE 1:0
`define ICC_CTRL_COMP 2
`define ICC_CTRL_SQRT 4:3
`define ICC_CTRL_LMODE 5
`define ICC_CTRL_LEN 6
`define ICC_CTRL_RST 7'h04

// Status field positions
`define ICC_STAT_CNT 4:0
`define ICC_STAT_EMPTY 5
`define ICC_STAT_FULL 6
`define ICC_STAT_BUSY 7
`define ICC_DATA_VALID 16

// Encodings
`define ICC_TYPE_TC 2'h0
`define ICC_TYPE_VOLT 2'h2
`define ICC_TYPE_CURR 2'h3
`define ICC_SQRT_OFF 2'h0
`define ICC_SQRT_UNITY 2'h1
`define ICC_SQRT_ZERO 2'h2
`define ICC_LIN_BIAS 1'h0
`define ICC_LIN_APPROX 1'h1

// Setting limits, 0.1 units; time constants in whole seconds
`define ICC_EXT_MIN 16'shFF9C
`define ICC_EXT_MAX 16'sh0258
`define ICC_BIAS_MIN 16'shFC18
`define ICC_BIAS_MAX 16'sh03E8
`define ICC_TC_MAX 16'sh0078
`define ICC_LC_MAX 16'sh0032
`define ICC_BP_MIN 16'shFD65
`define ICC_BP_MAX 16'sh041A

`endif

// ### logic/icc_pkg.sv
// Purpose: Types shared by the input conditioning chain.
// Assumes: Constants come from icc_params.svh.
// Notes: Breakpoint arrays are packed so the whole state is one struct.
package icc_pkg;

   // Processing sequence, one-hot
   typedef enum logic [8:0] {
      ST_IDLE  = 9'h001,
      ST_COMP  = 9'h002,
      ST_SQRT  = 9'h004,
      ST_LIN   = 9'h008,
      ST_ABIAS = 9'h010,
      ST_AFILT = 9'h020,
      ST_PBIAS = 9'h040,
      ST_PFILT = 9'h080,
      ST_PUSH  = 9'h100
   } icc_fsm_type;

   // One converted sample with its cold-junction term
   typedef struct packed {
      logic [15:0] value;
      logic [15:0] cj;
   } icc_sample_type;

   // Software settings
   typedef struct packed {
      logic [1:0] in_type;
      logic comp_en;
      logic [1:0] sqrt_mode;
      logic lin_mode;
      logic lin_en;
      logic [15:0] ext_jt;
      logic [15:0] pv_bias;
      logic [15:0] pv_tc;
      logic [15:0] a_bias;
      logic [15:0] a_tc;
      logic [15:0] low_cut;
      logic [10:0][15:0] bp_in;
      logic [10:0][15:0] bp_out;
   } icc_cfg_type;

   // Whole state of the chain
   typedef struct packed {
      icc_fsm_type st;
      logic [15:0] work;
      logic [15:0] cj;
      logic [15:0] a_y;
      logic [15:0] p_y;
      logic a_prim;
      logic p_prim;
      logic [16:0] a_coef;
      logic [16:0] p_coef;
      logic ack;
      logic [31:0] rdata;
      icc_cfg_type cfg;
   } icc_state_type;

endpackage

// ### logic/icc_fifo.sv
// Purpose: Small synchronous FIFO for conditioned values.
// Assumes: One clock; in_ready and out_valid are honest full and empty.
// Notes: Read data are taken straight from the head slot.
`timescale 1ns/1ps
module icc_fifo #(
   parameter int W = 16,
   parameter int D = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   // Fill level
   output logic [$clog2(D):0] count
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } icc_fifo_state_type;

   icc_fifo_state_type s_r;
   icc_fifo_state_type s_nxt;

   // Extra pointer bit tells full from empty
   assign count = s_r.wp - s_r.rp;
   assign in_ready = (count != (AW + 1)'(D));
   assign out_valid = (s_r.wp != s_r.rp);
   assign out_data = s_r.mem[s_r.rp[AW-1:0]];

   // Push and pop may share a cycle
   always_comb begin
      s_nxt = s_r;
      if (in_valid && in_ready) begin
         s_nxt.mem[s_r.wp[AW-1:0]] = in_data;
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// ### bench/icc_src.sv
// Purpose: Converter-side sample source for icc_chain.
// Assumes: The bench loads samples into q.
// Notes: Idle data toggles so a stale word never looks offered.
`timescale 1ns/1ps
module icc_src (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Sample stream
   output logic sample_valid,
   input wire logic sample_ready,
   output icc_pkg::icc_sample_type sample_data
);
   icc_pkg::icc_sample_type q[$];
   // Hold each offer until taken, then move on
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sample_valid <= 1'b0;
         sample_data <= 32'h0000_0000;
      end else begin
         if (sample_valid && sample_ready) void'(q.pop_front());
         sample_valid <= q.size() != 0;
         sample_data <= q.size() != 0 ? q[0] : ~sample_data;
      end
   end
endmodule

// ### bench/icc_chain_tb.sv
// Purpose: Self-checking bench of icc_chain.
// Assumes: Filters stay off until the last step, whose lag result is worked out exactly.
// Notes: Results are popped through the DATA word.
`timescale 1ns/1ps
module icc_chain_tb;
   logic ref_clk, resetn, rd, wr, sv, sr, w;
   logic [5:0] a;
   logic [31:0] wd, rdat, q;
   icc_pkg::icc_sample_type sd;
   int mismatches, checks, seed, v, c;
   int cyc = 0;
   logic [15:0] expq[$];
   icc_chain dut (.ref_clk(ref_clk), .resetn(resetn), .avs_address(a), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(w),
      .sample_valid(sv), .sample_ready(sr), .sample_data(sd));
   icc_src src (.ref_clk(ref_clk), .resetn(resetn), .sample_valid(sv), .sample_ready(sr), .sample_data(sd));
   task automatic complete_run();
      if (mismatches == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // Request held until waitrequest is sampled low at a rising edge; read data taken there
   task automatic bus(input logic we, input logic [5:0] ad, input logic [31:0] d);
      @(posedge ref_clk);
      a <= ad;
      wd <= d;
      wr <= we;
      rd <= !we;
      do @(posedge ref_clk);
      while (w !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic poll();
      do bus(1'b0, 6'h08, 32'h0);
      while (q[16] !== 1'b1);
   endtask
   task automatic smp(input logic [6:0] ctl, input int val, input int cj, input int exp);
      bus(1'b1, 6'h00, {25'h0, ctl});
      src.q.push_back({val[15:0], cj[15:0]});
      expq.push_back(exp[15:0]);
      poll();
   endtask
   // Each popped result is matched against the oldest note
   always @(negedge ref_clk) begin
      if (rd && w === 1'b0 && a == 6'h08 && rdat[16] === 1'b1 && expq.size() != 0)
         cmp(rdat[15:0], expq.pop_front());
   end
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // Hang guard, far above the fewer than one thousand cycles needed
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         mismatches++;
         complete_run();
      end
   end
   initial begin
      seed = 9725;
      resetn = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      a = 6'h00;
      wd = 32'h0;
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      bus(1'b1, 6'h01, 32'h0000_02BC);
      bus(1'b0, 6'h01, 32'h0);
      cmp(q[15:0], 16'h0258);
      for (int i = 0; i < 4; i++) begin
         v = $random(seed) % 500;
         c = $random(seed) % 100;
         smp(7'h04, v, c, v + c);
         smp(7'h00, v, c, v + 600);
         smp(7'h06, v, c, v);
      end
      bus(1'b1, 6'h02, 32'h0000_0019);
      bus(1'b1, 6'h04, 32'hFFFF_FFF9);
      bus(1'b1, 6'h06, 32'h0000_0032);
      smp(7'h04, 100, 5, 123);
      smp(7'h0A, 30, 0, 48);
      smp(7'h12, 30, 0, 18);
      smp(7'h12, 400, 0, 650);
      smp(7'h14, 400, 0, 418);
      smp(7'h02, 400, 0, 418);
      for (int i = 0; i < 11; i++) bus(1'b1, 6'h10 + i[5:0], i * 100);
      for (int i = 0; i < 11; i++) bus(1'b1, 6'h20 + i[5:0], 10 + i * 10);
      smp(7'h42, -50, 0, -22);
      smp(7'h42, 250, 0, 303);
      smp(7'h42, 1050, 0, 1178);
      for (int i = 0; i < 11; i++) bus(1'b1, 6'h20 + i[5:0], i * 50);
      smp(7'h62, -50, 0, -7);
      smp(7'h62, 250, 0, 143);
      smp(7'h62, 1050, 0, 543);
      bus(1'b1, 6'h00, 32'h0000_0002);
      // Seventeen samples: sixteen fill the queue, the last one stalls
      for (int i = 0; i < 17; i++) begin
         v = $random(seed) % 500;
         src.q.push_back({v[15:0], 16'h0000});
         expq.push_back(v[15:0] + 16'h0012);
      end
      repeat (250) @(posedge ref_clk);
      bus(1'b0, 6'h07, 32'h0);
      cmp({8'h0, q[7:0]}, 16'h00D0);
      repeat (17) poll();
      bus(1'b0, 6'h07, 32'h0);
      cmp({8'h0, q[7:0]}, 16'h0020);
      // One lag step from the last result with a one-second time constant
      c = v + 18;
      bus(1'b1, 6'h03, 32'h0000_0001);
      smp(7'h02, 300, 0, c + (((318 - c) * (6553600 / 1100)) >>> 16));
      complete_run();
   end
endmodule
